// file: rcal_pkg.sv
/*
 * Shared constants and types for the calendar register section:
 * register indices, field positions, reset values and the carrier structs.
 * Assumes a 32-bit Avalon-MM bus with byte addresses; each register index
 * sits at byte address four times the index.
 */
package rcal_pkg;

   // Register indices (byte address = 4 * index)
   localparam logic [5:0] IDX_FLAG_CTRL  = 6'h00;
   localparam logic [5:0] IDX_MODE_CTRL  = 6'h01;
   localparam logic [5:0] IDX_WEEKDAY    = 6'h13;
   localparam logic [5:0] IDX_MONTHDAY   = 6'h14;
   localparam logic [5:0] IDX_MONTH      = 6'h15;
   localparam logic [5:0] IDX_YEAR       = 6'h16;
   localparam logic [5:0] IDX_YEAR_HIGH  = 6'h17;
   localparam logic [5:0] IDX_ALM_MINUTE = 6'h18;
   localparam logic [5:0] IDX_ALM_HOUR   = 6'h19;
   localparam logic [5:0] IDX_ALM_WDAY   = 6'h1A;
   localparam logic [5:0] IDX_ALM_MDAY   = 6'h1B;
   localparam logic [5:0] IDX_IRQ_STATUS = 6'h20;
   localparam logic [5:0] IDX_IRQ_CLEAR  = 6'h21;
   localparam logic [5:0] IDX_IRQ_ENABLE = 6'h22;

   // First control register fields
   localparam int FC_TEV_IE   = 6;
   localparam int FC_ALM_IE   = 5;
   localparam int FC_RDY_IE   = 4;
   localparam int FC_TEV_FLAG = 2;
   localparam int FC_ALM_FLAG = 1;
   localparam int FC_RDY_FLAG = 0;
   localparam logic [7:0] FC_RESET = 8'h00;

   // Second control register fields
   localparam int MC_FORMAT  = 7;
   localparam int MC_HOLD    = 6;
   localparam int MC_MODE    = 5;
   localparam int MC_STABLE  = 4;
   localparam int MC_SRC_LSB = 2;
   localparam int MC_TEV_LSB = 0;
   localparam logic [7:0] MC_RESET = 8'h40;

   // Calendar contents after reset or a mode or format change, and the alarm reset byte
   localparam logic [7:0]  CAL_DAY_INIT   = 8'h01;
   localparam logic [7:0]  CAL_MONTH_INIT = 8'h01;
   localparam logic [7:0]  CAL_WDAY_INIT  = 8'h00;
   localparam logic [15:0] CAL_YEAR_INIT  = 16'h0000;
   localparam logic [7:0]  BYTE_CLEAR     = 8'h00;

   typedef struct packed {
      logic       decimal_format_sel;
      logic       count_hold;
      logic       calendar_mode_sel;
      logic [1:0] count_source_sel;
      logic [1:0] time_event_sel;
   } rcal_cfg_type;

   typedef struct packed {
      logic [15:0] calendar_year;
      logic [7:0]  month_of_year;
      logic [7:0]  day_of_month;
      logic [7:0]  day_of_week;
   } rcal_date_type;

   typedef struct packed {
      logic [7:0] alarm_monthday;
      logic [7:0] alarm_weekday;
      logic [7:0] alarm_hour;
      logic [7:0] alarm_minute;
   } rcal_alarm_type;

endpackage : rcal_pkg

// file: rcal_regs.sv
/*
 * Register section of the calendar clock: date, year, alarm and the two
 * control registers, an Avalon-MM slave with waitrequest, event flags and
 * a level interrupt.
 * Assumes the counting logic runs on sys_clk_i and supplies its event
 * pulses and the stable level on that same clock.
 */
// The Avalon-MM register port was left to the implementer.
`timescale 1ns/1ps

module rcal_regs
   import rcal_pkg::*;
(
   // Clock and reset
   input  wire logic           sys_clk_i,
   input  wire logic           sys_rst_i,
   // Avalon-MM slave
   input  wire logic [7:0]     avs_address_i,
   input  wire logic           avs_read_i,
   input  wire logic           avs_write_i,
   input  wire logic [31:0]    avs_writedata_i,
   input  wire logic [3:0]     avs_byteenable_i,
   output logic [31:0]         avs_readdata_o,
   output logic                avs_waitrequest_o,
   // Events from the counting logic
   input  wire logic           time_event_i,
   input  wire logic           alarm_event_i,
   input  wire logic           values_stable_i,
   // Configuration and contents for the counting logic
   output rcal_cfg_type        cfg_o,
   output rcal_date_type       date_o,
   output rcal_alarm_type      alarm_o,
   output logic                counter_clear_o,
   output logic                counter_hold_o,
   output logic                prescaler_hold_o,
   // Interrupt
   output logic                irq_o
);

   logic [7:0]     flag_ctrl_reg;
   logic [7:0]     flag_ctrl_next;
   rcal_cfg_type   cfg_reg;
   rcal_date_type  date_reg;
   rcal_alarm_type alarm_reg;
   logic           waitrequest_reg;
   logic [31:0]    readdata_reg;
   logic [31:0]    read_mux;
   logic           counter_clear_reg;
   logic           counter_hold_reg;
   logic           prescaler_hold_reg;
   logic           irq_reg;
   logic           stable_prev_reg;
   logic [5:0]     reg_index;
   logic           bus_req;
   logic           wr_take;
   logic           wr_flag;
   logic           wr_mode;
   logic           wr_clear;
   logic           wr_enable;
   logic           mode_change;
   logic           stable_view;
   logic           ready_event;
   logic [7:0]     mode_wdata;
   logic [2:0]     clear_bits;

   assign reg_index = avs_address_i[7:2];
   assign bus_req   = avs_read_i | avs_write_i;
   // A write lands only at the edge where waitrequest is sampled low
   assign wr_take   = avs_write_i & ~waitrequest_reg;
   assign wr_flag   = wr_take & avs_byteenable_i[0] & (reg_index == IDX_FLAG_CTRL);
   assign wr_mode   = wr_take & avs_byteenable_i[0] & (reg_index == IDX_MODE_CTRL);
   assign wr_clear  = wr_take & avs_byteenable_i[0] & (reg_index == IDX_IRQ_CLEAR);
   assign wr_enable = wr_take & avs_byteenable_i[0] & (reg_index == IDX_IRQ_ENABLE);

   assign mode_wdata  = avs_writedata_i[7:0];
   // Changing mode or number format restarts the calendar
   assign mode_change = wr_mode &
      ((mode_wdata[MC_MODE] != cfg_reg.calendar_mode_sel) |
       (mode_wdata[MC_FORMAT] != cfg_reg.decimal_format_sel));

   assign stable_view = values_stable_i & cfg_reg.calendar_mode_sel;
   assign ready_event = stable_view & ~stable_prev_reg;
   assign clear_bits  = wr_clear ? avs_writedata_i[2:0] : 3'h0;

   // Bus handshake: one wait cycle, then the answer
   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i)
      begin
         waitrequest_reg <= 1'b1;
      end
      else
      begin
         waitrequest_reg <= ~(bus_req & waitrequest_reg);
      end
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i)
      begin
         readdata_reg <= 32'h0000_0000;
      end
      else if (avs_read_i & waitrequest_reg)
      begin
         readdata_reg <= read_mux;
      end
   end

   // Read multiplexer; unmapped addresses read zero
   always_comb
   begin
      read_mux = 32'h0000_0000;
      case (reg_index)
         IDX_FLAG_CTRL:
         begin
            read_mux[7:0] = flag_ctrl_reg;
         end
         IDX_MODE_CTRL:
         begin
            read_mux[MC_FORMAT]                = cfg_reg.decimal_format_sel;
            read_mux[MC_HOLD]                  = cfg_reg.count_hold;
            read_mux[MC_MODE]                  = cfg_reg.calendar_mode_sel;
            read_mux[MC_STABLE]                = stable_view;
            read_mux[MC_SRC_LSB+1:MC_SRC_LSB]  = cfg_reg.count_source_sel;
            read_mux[MC_TEV_LSB+1:MC_TEV_LSB]  = cfg_reg.time_event_sel;
         end
         IDX_WEEKDAY:
         begin
            read_mux[7:0] = date_reg.day_of_week;
         end
         IDX_MONTHDAY:
         begin
            read_mux[15:0] = {date_reg.month_of_year, date_reg.day_of_month};
         end
         IDX_MONTH:
         begin
            read_mux[7:0] = date_reg.month_of_year;
         end
         IDX_YEAR:
         begin
            read_mux[15:0] = date_reg.calendar_year;
         end
         IDX_YEAR_HIGH:
         begin
            read_mux[7:0] = date_reg.calendar_year[15:8];
         end
         IDX_ALM_MINUTE:
         begin
            read_mux[15:0] = {alarm_reg.alarm_hour, alarm_reg.alarm_minute};
         end
         IDX_ALM_HOUR:
         begin
            read_mux[7:0] = alarm_reg.alarm_hour;
         end
         IDX_ALM_WDAY:
         begin
            read_mux[15:0] = {alarm_reg.alarm_monthday, alarm_reg.alarm_weekday};
         end
         IDX_ALM_MDAY:
         begin
            read_mux[7:0] = alarm_reg.alarm_monthday;
         end
         IDX_IRQ_STATUS:
         begin
            read_mux[2:0] = flag_ctrl_reg[2:0];
         end
         IDX_IRQ_ENABLE:
         begin
            read_mux[2:0] = flag_ctrl_reg[6:4];
         end
         default:
         begin
            read_mux = 32'h0000_0000;
         end
      endcase
   end

   // Flags and enables; a hardware event wins over a clear in the same cycle
   always_comb
   begin
      flag_ctrl_next = flag_ctrl_reg;
      if (wr_flag)
      begin
         flag_ctrl_next = mode_wdata;
      end
      if (wr_enable)
      begin
         flag_ctrl_next[6:4] = avs_writedata_i[2:0];
      end
      flag_ctrl_next[2:0] = flag_ctrl_next[2:0] & ~clear_bits;
      if (time_event_i)
      begin
         flag_ctrl_next[FC_TEV_FLAG] = 1'b1;
      end
      if (alarm_event_i)
      begin
         flag_ctrl_next[FC_ALM_FLAG] = 1'b1;
      end
      if (ready_event)
      begin
         flag_ctrl_next[FC_RDY_FLAG] = 1'b1;
      end
      flag_ctrl_next[7] = 1'b0;
      flag_ctrl_next[3] = 1'b0;
      if (~cfg_reg.calendar_mode_sel)
      begin
         flag_ctrl_next[FC_ALM_IE]   = 1'b0;
         flag_ctrl_next[FC_ALM_FLAG] = 1'b0;
      end
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i)
      begin
         flag_ctrl_reg <= FC_RESET;
      end
      else
      begin
         flag_ctrl_reg <= flag_ctrl_next;
      end
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i)
      begin
         stable_prev_reg <= 1'b0;
      end
      else
      begin
         stable_prev_reg <= stable_view;
      end
   end

   // Second control register
   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i)
      begin
         cfg_reg <= rcal_cfg_type'({MC_RESET[7:5], MC_RESET[3:0]});
      end
      else if (wr_mode)
      begin
         cfg_reg.decimal_format_sel <= mode_wdata[MC_FORMAT];
         cfg_reg.count_hold         <= mode_wdata[MC_HOLD];
         cfg_reg.calendar_mode_sel  <= mode_wdata[MC_MODE];
         cfg_reg.count_source_sel   <= mode_wdata[MC_SRC_LSB+1:MC_SRC_LSB];
         cfg_reg.time_event_sel     <= mode_wdata[MC_TEV_LSB+1:MC_TEV_LSB];
      end
   end

   // Date and weekday storage
   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i | mode_change)
      begin
         date_reg.day_of_week   <= CAL_WDAY_INIT;
         date_reg.day_of_month  <= CAL_DAY_INIT;
         date_reg.month_of_year <= CAL_MONTH_INIT;
         date_reg.calendar_year <= CAL_YEAR_INIT;
      end
      else if (wr_take)
      begin
         if ((reg_index == IDX_WEEKDAY) & avs_byteenable_i[0])
         begin
            date_reg.day_of_week <= avs_writedata_i[7:0];
         end
         if ((reg_index == IDX_MONTHDAY) & avs_byteenable_i[0])
         begin
            date_reg.day_of_month <= avs_writedata_i[7:0];
         end
         if ((reg_index == IDX_MONTHDAY) & avs_byteenable_i[1])
         begin
            date_reg.month_of_year <= avs_writedata_i[15:8];
         end
         if ((reg_index == IDX_MONTH) & avs_byteenable_i[0])
         begin
            date_reg.month_of_year <= avs_writedata_i[7:0];
         end
         if ((reg_index == IDX_YEAR) & avs_byteenable_i[0])
         begin
            date_reg.calendar_year[7:0] <= avs_writedata_i[7:0];
         end
         if ((reg_index == IDX_YEAR) & avs_byteenable_i[1])
         begin
            date_reg.calendar_year[15:8] <= avs_writedata_i[15:8];
         end
         if ((reg_index == IDX_YEAR_HIGH) & avs_byteenable_i[0])
         begin
            date_reg.calendar_year[15:8] <= avs_writedata_i[7:0];
         end
      end
   end

   // Alarm storage
   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i)
      begin
         alarm_reg <= rcal_alarm_type'({BYTE_CLEAR, BYTE_CLEAR, BYTE_CLEAR, BYTE_CLEAR});
      end
      else if (wr_take)
      begin
         if ((reg_index == IDX_ALM_MINUTE) & avs_byteenable_i[0])
         begin
            alarm_reg.alarm_minute <= avs_writedata_i[7:0];
         end
         if ((reg_index == IDX_ALM_MINUTE) & avs_byteenable_i[1])
         begin
            alarm_reg.alarm_hour <= avs_writedata_i[15:8];
         end
         if ((reg_index == IDX_ALM_HOUR) & avs_byteenable_i[0])
         begin
            alarm_reg.alarm_hour <= avs_writedata_i[7:0];
         end
         if ((reg_index == IDX_ALM_WDAY) & avs_byteenable_i[0])
         begin
            alarm_reg.alarm_weekday <= avs_writedata_i[7:0];
         end
         if ((reg_index == IDX_ALM_WDAY) & avs_byteenable_i[1])
         begin
            alarm_reg.alarm_monthday <= avs_writedata_i[15:8];
         end
         if ((reg_index == IDX_ALM_MDAY) & avs_byteenable_i[0])
         begin
            alarm_reg.alarm_monthday <= avs_writedata_i[7:0];
         end
      end
   end

   // Controls for the counting logic
   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i)
      begin
         counter_clear_reg  <= 1'b0;
         counter_hold_reg   <= 1'b1;
         prescaler_hold_reg <= 1'b0;
      end
      else
      begin
         counter_clear_reg  <= mode_change;
         counter_hold_reg   <= cfg_reg.count_hold;
         prescaler_hold_reg <= cfg_reg.count_hold & cfg_reg.calendar_mode_sel;
      end
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i)
      begin
         irq_reg <= 1'b0;
      end
      else
      begin
         irq_reg <= |(flag_ctrl_next[2:0] & flag_ctrl_next[6:4]);
      end
   end

   assign avs_waitrequest_o = waitrequest_reg;
   assign avs_readdata_o    = readdata_reg;
   assign cfg_o             = cfg_reg;
   assign date_o            = date_reg;
   assign alarm_o           = alarm_reg;
   assign counter_clear_o   = counter_clear_reg;
   assign counter_hold_o    = counter_hold_reg;
   assign prescaler_hold_o  = prescaler_hold_reg;
   assign irq_o             = irq_reg;

endmodule : rcal_regs

// file: rcal_regs_monitor.sv
/* Port checker for the calendar register section.
   Assumes one clock domain and the bind at the foot of this file. */
`timescale 1ns/1ps
module rcal_regs_monitor
   import rcal_pkg::*;
(
   // Clock and reset
   input wire logic         sys_clk_i,
   input wire logic         sys_rst_i,
   // Register bus
   input wire logic [7:0]   avs_address_i,
   input wire logic         avs_read_i,
   input wire logic         avs_write_i,
   input wire logic [31:0]  avs_readdata_o,
   input wire logic         avs_waitrequest_o,
   // Events and outputs
   input wire logic         time_event_i,
   input wire logic         alarm_event_i,
   input wire logic         values_stable_i,
   input wire rcal_cfg_type cfg_o,
   input wire logic         counter_clear_o,
   input wire logic         counter_hold_o,
   input wire logic         prescaler_hold_o,
   input wire logic         irq_o
);
   wire logic fc_rd;
   wire logic mc_rd;
   assign fc_rd = avs_read_i && !avs_waitrequest_o && avs_address_i[7:2] == IDX_FLAG_CTRL;
   assign mc_rd = avs_read_i && !avs_waitrequest_o && avs_address_i[7:2] == IDX_MODE_CTRL;

   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (sys_rst_i);

   property p_reset_state;
      disable iff (1'h0) $fell(sys_rst_i) |-> cfg_o == 7'h20 && counter_hold_o
         && !prescaler_hold_o && !irq_o && avs_waitrequest_o;
   endproperty
   property p_wait_one;
      (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o;
   endproperty
   property p_wait_pulse;
      !avs_waitrequest_o |=> avs_waitrequest_o;
   endproperty
   property p_fc_reserved;
      fc_rd |-> avs_readdata_o[7] == 1'h0 && avs_readdata_o[3] == 1'h0;
   endproperty
   property p_counter_alarm;
      fc_rd && !cfg_o.calendar_mode_sel |-> avs_readdata_o[5] == 1'h0 && avs_readdata_o[1] == 1'h0;
   endproperty
   property p_counter_stable;
      mc_rd && !cfg_o.calendar_mode_sel |-> avs_readdata_o[4] == 1'h0;
   endproperty
   property p_irq_cause;
      $rose(irq_o) |-> $past(time_event_i || alarm_event_i || values_stable_i || avs_write_i);
   endproperty
   property p_clear_cause;
      counter_clear_o |-> ($past(avs_write_i) || $past(avs_write_i, 2)) ##1 !counter_clear_o;
   endproperty
   property p_hold_map;
      $stable(cfg_o) && $past(cfg_o, 2) == cfg_o |-> counter_hold_o == cfg_o.count_hold
         && prescaler_hold_o == (cfg_o.count_hold && cfg_o.calendar_mode_sel);
   endproperty

   a_reset_state: assert property (p_reset_state) else $error("bad reset state");
   a_wait_one: assert property (p_wait_one) else $error("no answer in one cycle");
   a_wait_pulse: assert property (p_wait_pulse) else $error("wait low too long");
   a_fc_reserved: assert property (p_fc_reserved) else $error("reserved bit set");
   a_counter_alarm: assert property (p_counter_alarm) else $error("counter alarm");
   a_counter_stable: assert property (p_counter_stable) else $error("stable in counter");
   a_irq_cause: assert property (p_irq_cause) else $error("irq without cause");
   a_clear_cause: assert property (p_clear_cause) else $error("stray counter clear");
   a_hold_map: assert property (p_hold_map) else $error("hold outputs wrong");

   c_irq: cover property ($rose(irq_o));
   c_clear: cover property (counter_clear_o);
   c_pre_hold: cover property (prescaler_hold_o);
endmodule : rcal_regs_monitor

bind rcal_regs rcal_regs_monitor rcal_regs_monitor_inst (.sys_clk_i, .sys_rst_i, .avs_address_i,
   .avs_read_i, .avs_write_i, .avs_readdata_o, .avs_waitrequest_o, .time_event_i,
   .alarm_event_i, .values_stable_i, .cfg_o, .counter_clear_o, .counter_hold_o,
   .prescaler_hold_o, .irq_o);

// file: test_rcal_regs.sv
/* Self-checking bench for the calendar register section.
   Assumes the checker is bound from its own file. */
`timescale 1ns/1ps
module test_rcal_regs
   import rcal_pkg::*;
;
   logic           sys_clk_i        = 1'h0;
   logic           sys_rst_i        = 1'h1;
   logic [7:0]     avs_address_i    = 8'h00;
   logic           avs_read_i       = 1'h0;
   logic           avs_write_i      = 1'h0;
   logic [31:0]    avs_writedata_i  = 32'h0;
   logic [3:0]     avs_byteenable_i = 4'h0;
   logic           time_event_i     = 1'h0;
   logic           alarm_event_i    = 1'h0;
   logic           values_stable_i  = 1'h0;
   logic [31:0]    avs_readdata_o;
   logic           avs_waitrequest_o;
   rcal_cfg_type   cfg_o;
   rcal_date_type  date_o;
   rcal_alarm_type alarm_o;
   logic           counter_clear_o;
   logic           counter_hold_o;
   logic           prescaler_hold_o;
   logic           irq_o;
   logic [31:0]    rdata;
   int             miscompares      = 0;
   int             samples_checked  = 0;
   int             clears           = 0;
   // Write, then read-back place and expected word
   logic [5:0]     t_idx[13] = '{IDX_MONTHDAY, IDX_MONTH, IDX_YEAR, IDX_YEAR_HIGH,
      IDX_ALM_MINUTE, IDX_ALM_WDAY, IDX_WEEKDAY, IDX_ALM_MINUTE, IDX_ALM_HOUR, IDX_ALM_MDAY,
      IDX_MONTH, IDX_YEAR, 6'h3F};
   logic [15:0]    t_dat[13] = '{16'h0C1F, 16'h0005, 16'h07E8, 16'h0012, 16'h1730,
      16'h1503, 16'h0006, 16'hFFFF, 16'h0022, 16'h0009, 16'h0007, 16'h0034, 16'h00FF};
   logic [3:0]     t_be[13]  = '{4'h3, 4'h1, 4'h3, 4'h1, 4'h3, 4'h3, 4'h1,
      4'h0, 4'h1, 4'h1, 4'h1, 4'h1, 4'hF};
   logic [5:0]     t_rd[13]  = '{IDX_MONTHDAY, IDX_MONTHDAY, IDX_YEAR, IDX_YEAR,
      IDX_ALM_HOUR, IDX_ALM_WDAY, IDX_WEEKDAY, IDX_ALM_MINUTE, IDX_ALM_MINUTE, IDX_ALM_WDAY,
      IDX_MONTH, IDX_YEAR_HIGH, 6'h3F};
   logic [15:0]    t_exp[13] = '{16'h0C1F, 16'h051F, 16'h07E8, 16'h12E8, 16'h0017,
      16'h1503, 16'h0006, 16'h1730, 16'h2230, 16'h0903, 16'h0007, 16'h0012, 16'h0000};

   rcal_regs rcal_regs_inst (.sys_clk_i, .sys_rst_i, .avs_address_i, .avs_read_i,
      .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o,
      .time_event_i, .alarm_event_i, .values_stable_i, .cfg_o, .date_o, .alarm_o,
      .counter_clear_o, .counter_hold_o, .prescaler_hold_o, .irq_o);

   always #4 sys_clk_i = ~sys_clk_i;

   always @(posedge sys_clk_i)
      if (counter_clear_o === 1'h1)
         clears <= clears + 1;

   task automatic conclude;
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : conclude

   task automatic chk(input string nm, input logic [47:0] exp, input logic [47:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   // One bus cycle; request held until waitrequest is seen low
   task automatic acc(input logic w, input logic [5:0] idx, input logic [31:0] d,
                      input logic [3:0] be);
      int n;
      n = 0;
      avs_address_i    <= {idx, 2'h0};
      avs_writedata_i  <= d;
      avs_byteenable_i <= be;
      avs_write_i      <= w;
      avs_read_i       <= !w;
      do
      begin
         @(posedge sys_clk_i);
         n++;
      end
      while (avs_waitrequest_o !== 1'h0 && n < 50);
      if (avs_waitrequest_o !== 1'h0)
         chk("waitrequest", 48'h0, 48'h1);
      rdata = avs_readdata_o;
      avs_write_i <= 1'h0;
      avs_read_i  <= 1'h0;
      @(posedge sys_clk_i);
   endtask : acc

   task automatic wr(input logic [5:0] idx, input logic [31:0] d);
      acc(1'h1, idx, d, 4'h1);
   endtask : wr

   task automatic rdc(input string nm, input logic [5:0] idx, input logic [31:0] exp);
      acc(1'h0, idx, 32'h0, 4'hF);
      chk(nm, {16'h0, exp}, {16'h0, rdata});
   endtask : rdc

   task automatic ev(input logic t, input logic a);
      time_event_i  <= t;
      alarm_event_i <= a;
      @(posedge sys_clk_i);
      time_event_i  <= 1'h0;
      alarm_event_i <= 1'h0;
      @(posedge sys_clk_i);
   endtask : ev

   initial
   begin
      #100000;
      miscompares++;
      conclude();
   end

   initial
   begin
      repeat (8) @(posedge sys_clk_i);
      sys_rst_i <= 1'h0;
      @(posedge sys_clk_i);
      rdc("flag_ctrl", IDX_FLAG_CTRL, 32'h00);
      rdc("mode_ctrl", IDX_MODE_CTRL, 32'h40);
      chk("irq", 48'h0, irq_o);
      $display("test reset done");
      acc(1'h1, IDX_MONTHDAY, 32'h0C1F, 4'h3);
      wr(IDX_MODE_CTRL, 32'h2F);
      rdc("date_word", IDX_MONTHDAY, 32'h0101);
      rdc("mode_ctrl", IDX_MODE_CTRL, 32'h2F);
      chk("cfg", 48'h1F, cfg_o);
      chk("clears", 48'h1, clears);
      foreach (t_idx[i])
      begin
         acc(1'h1, t_idx[i], {16'h0, t_dat[i]}, t_be[i]);
         rdc("table", t_rd[i], {16'h0, t_exp[i]});
      end
      chk("date", 48'h1234071F06, date_o);
      chk("alarm", 48'h09032230, alarm_o);
      $display("test registers done");
      wr(IDX_FLAG_CTRL, 32'h88);
      rdc("flag_ctrl", IDX_FLAG_CTRL, 32'h00);
      wr(IDX_IRQ_ENABLE, 32'h04);
      ev(1'h1, 1'h0);
      chk("irq", 48'h1, irq_o);
      rdc("flag_ctrl", IDX_FLAG_CTRL, 32'h44);
      wr(IDX_IRQ_CLEAR, 32'h04);
      rdc("status", IDX_IRQ_STATUS, 32'h0);
      chk("irq", 48'h0, irq_o);
      ev(1'h0, 1'h1);
      rdc("status", IDX_IRQ_STATUS, 32'h2);
      chk("irq", 48'h0, irq_o);
      wr(IDX_FLAG_CTRL, 32'h22);
      rdc("flag_ctrl", IDX_FLAG_CTRL, 32'h22);
      chk("irq", 48'h1, irq_o);
      values_stable_i <= 1'h1;
      repeat (2) @(posedge sys_clk_i);
      rdc("status", IDX_IRQ_STATUS, 32'h3);
      rdc("mode_ctrl", IDX_MODE_CTRL, 32'h3F);
      wr(IDX_FLAG_CTRL, 32'h15);
      rdc("flag_ctrl", IDX_FLAG_CTRL, 32'h15);
      chk("irq", 48'h1, irq_o);
      $display("test flags done");
      wr(IDX_FLAG_CTRL, 32'h32);
      wr(IDX_MODE_CTRL, 32'h00);
      rdc("flag_ctrl", IDX_FLAG_CTRL, 32'h10);
      rdc("mode_ctrl", IDX_MODE_CTRL, 32'h00);
      ev(1'h0, 1'h1);
      rdc("flag_ctrl", IDX_FLAG_CTRL, 32'h10);
      wr(IDX_MODE_CTRL, 32'h40);
      rdc("mode_ctrl", IDX_MODE_CTRL, 32'h40);
      chk("holds", 48'h2, {counter_hold_o, prescaler_hold_o});
      wr(IDX_MODE_CTRL, 32'h60);
      rdc("mode_ctrl", IDX_MODE_CTRL, 32'h70);
      chk("holds", 48'h3, {counter_hold_o, prescaler_hold_o});
      chk("clears", 48'h3, clears);
      wr(IDX_WEEKDAY, 32'h05);
      wr(IDX_MODE_CTRL, 32'hE0);
      rdc("mode_ctrl", IDX_MODE_CTRL, 32'hF0);
      chk("date", 48'h0000010100, date_o);
      chk("clears", 48'h4, clears);
      $display("test modes done");
      sys_rst_i       <= 1'h1;
      values_stable_i <= 1'h0;
      repeat (8) @(posedge sys_clk_i);
      sys_rst_i <= 1'h0;
      @(posedge sys_clk_i);
      rdc("mode_ctrl", IDX_MODE_CTRL, 32'h40);
      rdc("flag_ctrl", IDX_FLAG_CTRL, 32'h00);
      chk("irq", 48'h0, irq_o);
      $display("test second reset done");
      conclude();
   end
endmodule : test_rcal_regs
